// ---- hw/tss_key.sv ----
// One key: detection integrator, detect timing and per-key recalibration
`timescale 1ns/100ps
module tss_key (
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    input  wire logic       soft_rst,
    input  wire logic       cal_all,
    input  wire logic       sample,
    input  wire logic       above,
    input  wire logic       pos_over,
    input  wire logic [7:0] di_limit,
    input  wire logic [7:0] nrd_limit,
    output logic            detect,
    output logic            cal_busy
);
    import tss_pkg::*;

    tss_key_st_t st;
    tss_key_st_t nx;

    // Next state of the key
    always_comb
    begin
        nx = st;
        if (soft_rst)
        begin
            nx = '0;
        end
        else if (cal_all)
        begin
            nx = '0;
            nx.cal_left = CAL_SCANS;
        end
        else if (sample)
        begin
            if (st.cal_left != 4'h0)
            begin
                nx = '0;
                nx.cal_left = st.cal_left - 4'h1;
            end
            else if (pos_over)
            begin
                nx = '0;
                nx.cal_left = CAL_SCANS;
            end
            else if (st.det && nrd_limit != 8'h00 && st.dtime >= nrd_limit)
            begin
                nx = '0;
                nx.cal_left = CAL_SCANS;
            end
            else if (above)
            begin
                if (st.det)
                    nx.dtime = st.dtime + {7'h00, st.dtime != 8'hFF};
                else if ({1'b0, st.integ} + 9'h001 >= {1'b0, di_limit})
                    nx.det = 1'b1;
                else
                    nx.integ = st.integ + 8'h01;
            end
            else
            begin
                nx.integ = 8'h00;
                nx.det = 1'b0;
                nx.dtime = 8'h00;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            st <= '0;
        else
            st <= nx;
    end

    assign detect = st.det;
    assign cal_busy = st.cal_left != 4'h0;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    integ_clear_a: assert property (
        sample && !above && st.cal_left == 4'h0 && !pos_over && !cal_all && !soft_rst
        |=> st.integ == 8'h00 && !detect)
        else $error("integrator not cleared on dropout");

    det_limit_a: assert property (
        $rose(detect) |-> {1'b0, $past(st.integ)} + 9'h001 >= {1'b0, $past(di_limit)} && $past(above))
        else $error("detect declared before integrator limit");
endmodule

// ---- hw/tss_pkg.sv ----
// Package: constants, carriers and state types of the touch scan sequencer
package tss_pkg;
    // Clock rate and documented times
    localparam int CLK_KHZ        = 200000;
    localparam int INIT_TIME_MS   = 70;
    localparam int CYCLE_TIME_MS  = 16;
    localparam int RSTPIN_TIME_US = 10;
    // Derived cycle counts, calibration scan count and PWM divider
    localparam int INIT_CYC   = INIT_TIME_MS * CLK_KHZ;
    localparam int CYCLE_CYC  = CYCLE_TIME_MS * CLK_KHZ;
    localparam int RSTPIN_CYC = (RSTPIN_TIME_US * CLK_KHZ + 999) / 1000;
    localparam logic [3:0] CAL_SCANS = 4'hF;
    localparam logic [7:0] PWM_DIV   = 8'hFA;

    // Register byte offsets
    localparam logic [7:0] A_GEN   = 8'h00;
    localparam logic [7:0] A_KEYS  = 8'h04;
    localparam logic [7:0] A_GPIN  = 8'h08;
    localparam logic [7:0] A_CAL   = 8'h0C;
    localparam logic [7:0] A_RST   = 8'h10;
    localparam logic [7:0] A_LP    = 8'h14;
    localparam logic [7:0] A_DI    = 8'h18;
    localparam logic [7:0] A_NRD   = 8'h1C;
    localparam logic [7:0] A_AWAKE = 8'h20;
    localparam logic [7:0] A_DRIVE = 8'h24;
    localparam logic [7:0] A_DIR   = 8'h28;
    localparam logic [7:0] A_PWMEN = 8'h2C;
    localparam logic [7:0] A_PWMLV = 8'h30;
    localparam logic [7:0] A_WAKE  = 8'h34;
    localparam logic [7:0] A_USED  = 8'h38;

    typedef enum logic [1:0] {PH_INIT, PH_IDLE, PH_MEAS, PH_SLEEP} tss_phase_t;

    // Measurement front end link, all asynchronous to sys_clk
    typedef struct packed {
        logic        lclk;
        logic        done;
        logic        burst;
        logic [7:0]  pulses;
        logic [15:0] above;
        logic [15:0] pos_over;
    } tss_afe_t;

    typedef struct packed {
        logic [7:0]  lp;
        logic [7:0]  di;
        logic [7:0]  neg_recal_delay;
        logic [7:0]  awk;
        logic [10:0] drive;
        logic [2:0]  dir;
        logic [10:0] pwm_en;
        logic [3:0]  pwm_lvl;
        logic [2:0]  wake;
        logic [7:0]  used;
    } tss_cfg_t;

    localparam tss_cfg_t CFG_RESET = '{lp: 8'h01, di: 8'h04, neg_recal_delay: 8'h00, awk: 8'h10,
        drive: 11'h000, dir: 3'h0, pwm_en: 11'h000, pwm_lvl: 4'h8, wake: 3'h0, used: 8'hFF};

    typedef struct packed {
        logic [7:0] integ;
        logic       det;
        logic [7:0] dtime;
        logic [3:0] cal_left;
    } tss_key_st_t;

    typedef struct packed {
        tss_afe_t    afe_s1;
        tss_afe_t    afe_s2;
        logic        lclk_prev;
        logic [2:0]  gpio_s1;
        logic [2:0]  gpio_s2;
        logic [2:0]  gpio_prev;
        logic        rstp_s1;
        logic        rstp_s2;
        logic [11:0] rstp_cnt;
        tss_phase_t  phase;
        logic [23:0] tmr;
        logic [7:0]  lp_cnt;
        logic [7:0]  awake_cnt;
        logic        awake;
        logic        cal_all;
        logic        soft_rst;
        logic        meas_req;
        logic        overrun;
        logic        alert;
        logic [2:0]  pend;
        logic [15:0] key_prev;
        logic [7:0]  pwm_div;
        logic [3:0]  pwm_cnt;
        logic [3:0]  chirp;
        tss_cfg_t    cfg;
        logic [7:0]  drv;
        logic [2:0]  gout;
        logic [31:0] rdata;
    } tss_st_t;
endpackage

// ---- hw/tss_top.sv ----
// Touch scan sequencer: cycle timing, calibration, alert, sleep and outputs
//
// Contract
// - About 70 ms startup before measuring
// - Then alert low, calibrate over 15 scans
// - Never recalibrate on a periodic schedule
// - Recalibrate key stuck in detect too long
// - Recalibrate key above positive threshold
// - Host command triggers full key calibration
// - Alert low whenever key status changes
// - Later calibrations alert only if something detected
// - Reset pin low 10 us restarts fully; chirp and PWM counters are not reset
// - Bursts always chirp, never configurable
// - Per-key integrator confirms touch at limit
// - Below threshold clears integrator counter
// - Fixed 16 ms cycle, measure then idle
// - Low power interval sets idle measuring
// - Touch forces 16 ms until awake timeout
// - Overrun sets status flag, keeps running
// - Interval zero sleeps, no measure, no PWM
// - Wake on address match, reset, interval
// - Wake-enabled input edges in sleep alert
// - Three pins bidirectional, eight output only
// - PWM frozen during bursts, duty approximate
// - Used drive lines carry burst pulses
// - Alert released after changed bytes read
`timescale 1ns/100ps
module tss_top #(
    parameter int INIT_CYCLES  = tss_pkg::INIT_CYC,
    parameter int CYCLE_CYCLES = tss_pkg::CYCLE_CYC
) (
    input  wire logic             sys_clk,
    input  wire logic             resetn,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic [31:0]           prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire tss_pkg::tss_afe_t afe_in,
    output logic                  meas_req,
    output logic [15:0]           key_cal,
    output logic [3:0]            chirp_step,
    input  wire logic             rst_pin_n,
    input  wire logic             i2c_addr_match,
    input  wire logic [2:0]       gpio_in,
    output logic [2:0]            gpio_out,
    output logic [2:0]            gpio_oe,
    output logic [7:0]            drive_line_outputs,
    output logic                  status_alert_n
);
    import tss_pkg::*;

    tss_st_t     st;
    tss_st_t     nx;
    logic [15:0] det;
    logic [15:0] kcal;
    logic        lclk_rise;
    logic        sample;
    logic        tick;
    logic        wr;
    logic        rd;
    logic        hit;
    logic [31:0] rmux;
    logic [10:0] lvl;
    logic [2:0]  edges;

    // One integrator per key
    genvar k;
    generate
        for (k = 0; k < 16; k++)
        begin : g_key
            tss_key u_key (
                .sys_clk   (sys_clk),
                .resetn    (resetn),
                .soft_rst  (st.soft_rst),
                .cal_all   (st.cal_all),
                .sample    (sample),
                .above     (st.afe_s2.above[k]),
                .pos_over  (st.afe_s2.pos_over[k]),
                .di_limit  (st.cfg.di),
                .nrd_limit (st.cfg.neg_recal_delay),
                .detect    (det[k]),
                .cal_busy  (kcal[k])
            );
        end
    endgenerate

    // Register read mux and address decode
    always_comb
    begin
        hit = 1'b1;
        rmux = 32'h0000_0000;
        case (paddr)
            A_GEN:   rmux = {26'h000_0000, st.overrun, st.awake, st.phase == PH_SLEEP,
                             st.phase == PH_MEAS, |kcal, st.phase == PH_INIT};
            A_KEYS:  rmux = {16'h0000, det};
            A_GPIN:  rmux = {29'h0000_0000, st.gpio_s2};
            A_CAL:   rmux = 32'h0000_0000;
            A_RST:   rmux = 32'h0000_0000;
            A_LP:    rmux = {24'h00_0000, st.cfg.lp};
            A_DI:    rmux = {24'h00_0000, st.cfg.di};
            A_NRD:   rmux = {24'h00_0000, st.cfg.neg_recal_delay};
            A_AWAKE: rmux = {24'h00_0000, st.cfg.awk};
            A_DRIVE: rmux = {21'h00_0000, st.cfg.drive};
            A_DIR:   rmux = {29'h0000_0000, st.cfg.dir};
            A_PWMEN: rmux = {21'h00_0000, st.cfg.pwm_en};
            A_PWMLV: rmux = {28'h000_0000, st.cfg.pwm_lvl};
            A_WAKE:  rmux = {29'h0000_0000, st.cfg.wake};
            A_USED:  rmux = {24'h00_0000, st.cfg.used};
            default: hit = 1'b0;
        endcase
    end

    // Strobes from the synchronised link, the cycle timer and the APB access
    always_comb
    begin
        lclk_rise = st.afe_s2.lclk & ~st.lclk_prev;
        sample = lclk_rise & st.afe_s2.done & (st.phase == PH_MEAS);
        tick = st.tmr == 24'(CYCLE_CYCLES - 1);
        wr = psel & penable & pwrite;
        rd = psel & penable & ~pwrite;
    end

    // Static pin levels; PWM gate applies per pin
    generate
        for (k = 0; k < 11; k++)
        begin : g_lvl
            assign lvl[k] = st.cfg.drive[k] & (~st.cfg.pwm_en[k] | (st.pwm_cnt < st.cfg.pwm_lvl));
        end
    endgenerate

    // Next state of the sequencer
    always_comb
    begin
        nx = st;
        nx.cal_all = 1'b0;
        nx.soft_rst = 1'b0;
        nx.meas_req = 1'b0;

        // Two-flop synchronisers for the link and pins
        nx.afe_s1 = afe_in;
        nx.afe_s2 = st.afe_s1;
        nx.lclk_prev = st.afe_s2.lclk;
        nx.gpio_s1 = gpio_in;
        nx.gpio_s2 = st.gpio_s1;
        nx.gpio_prev = st.gpio_s2;
        nx.rstp_s1 = rst_pin_n;
        nx.rstp_s2 = st.rstp_s1;

        if (!st.rstp_s2)
            nx.rstp_cnt = st.rstp_cnt + {11'h000, st.rstp_cnt != 12'hFFF};
        else
        begin
            nx.soft_rst = st.rstp_cnt >= 12'(RSTPIN_CYC);
            nx.rstp_cnt = 12'h000;
        end

        // Register reads: capture in setup, clear on access
        if (psel && !penable)
            nx.rdata = rmux;
        if (rd && paddr == A_GEN)
        begin
            nx.pend[0] = 1'b0;
            nx.overrun = 1'b0;
        end
        if (rd && paddr == A_KEYS)
            nx.pend[1] = 1'b0;
        if (rd && paddr == A_GPIN)
            nx.pend[2] = 1'b0;

        // Register writes
        if (wr)
        begin
            case (paddr)
                A_CAL:   nx.cal_all = 1'b1;
                A_RST:   nx.soft_rst = pwdata != 32'h0000_0000;
                A_LP:    nx.cfg.lp = pwdata[7:0];
                A_DI:    nx.cfg.di = pwdata[7:0];
                A_NRD:   nx.cfg.neg_recal_delay = pwdata[7:0];
                A_AWAKE: nx.cfg.awk = pwdata[7:0];
                A_DRIVE: nx.cfg.drive = pwdata[10:0];
                A_DIR:   nx.cfg.dir = pwdata[2:0];
                A_PWMEN: nx.cfg.pwm_en = pwdata[10:0];
                A_PWMLV: nx.cfg.pwm_lvl = pwdata[3:0];
                A_WAKE:  nx.cfg.wake = pwdata[2:0];
                A_USED:  nx.cfg.used = pwdata[7:0];
                default: nx.rdata = st.rdata;
            endcase
        end

        // Cycle sequencer
        case (st.phase)
            PH_INIT:
            begin
                nx.tmr = st.tmr + 24'h00_0001;
                if (st.tmr == 24'(INIT_CYCLES - 1))
                begin
                    nx.phase = PH_IDLE;
                    nx.tmr = 24'h00_0000;
                    nx.cal_all = 1'b1;
                    nx.pend[1] = 1'b1;
                end
            end
            PH_IDLE:
            begin
                nx.tmr = st.tmr + 24'h00_0001;
                if (tick)
                begin
                    nx.tmr = 24'h00_0000;
                    // interval zero sleeps; an address wake runs until its awake timeout
                    if (st.cfg.lp == 8'h00 && !st.awake)
                        nx.phase = PH_SLEEP;
                    else if (st.awake || st.lp_cnt + 8'h01 >= st.cfg.lp)
                    begin
                        nx.phase = PH_MEAS;
                        nx.meas_req = 1'b1;
                        nx.lp_cnt = 8'h00;
                    end
                    else
                        nx.lp_cnt = st.lp_cnt + 8'h01;
                    if (st.awake && det == 16'h0000)
                    begin
                        nx.awake_cnt = st.awake_cnt + 8'h01;
                        if (st.awake_cnt + 8'h01 >= st.cfg.awk)
                            nx.awake = 1'b0;
                    end
                end
            end
            PH_MEAS:
            begin
                nx.tmr = st.tmr + 24'h00_0001;
                if (tick)
                begin
                    nx.tmr = 24'h00_0000;
                    nx.overrun = 1'b1;
                    nx.pend[0] = 1'b1;
                end
                if (sample)
                    nx.phase = PH_IDLE;
            end
            PH_SLEEP:
            begin
                if (i2c_addr_match)
                begin
                    nx.phase = PH_IDLE;
                    nx.awake = 1'b1;
                    nx.awake_cnt = 8'h00;
                end
                if (wr && paddr == A_LP && pwdata[7:0] != 8'h00)
                    nx.phase = PH_IDLE;
            end
            default: nx.phase = PH_INIT;
        endcase

        if ((det & ~st.key_prev) != 16'h0000)
        begin
            nx.awake = 1'b1;
            nx.awake_cnt = 8'h00;
        end
        if (det != 16'h0000)
            nx.awake_cnt = 8'h00;

        if (det != st.key_prev)
            nx.pend[1] = 1'b1;
        nx.key_prev = det;

        // input edges; only wake pins in sleep
        edges = (st.gpio_s2 ^ st.gpio_prev) & ~st.cfg.dir;
        if (st.phase == PH_SLEEP)
            edges = edges & st.cfg.wake;
        if (edges != 3'h0)
            nx.pend[2] = 1'b1;

        if (lclk_rise && st.afe_s2.burst)
            nx.chirp = st.chirp + 4'h1;

        if (st.phase != PH_SLEEP)
        begin
            if (!st.afe_s2.burst)
            begin
                nx.pwm_div = (st.pwm_div == PWM_DIV) ? 8'h00 : st.pwm_div + 8'h01;
                if (st.pwm_div == PWM_DIV)
                    nx.pwm_cnt = st.pwm_cnt + 4'h1;
            end
            nx.drv = (st.afe_s2.pulses & st.cfg.used & {8{st.afe_s2.burst}}) |
                     (lvl[7:0] & ~(st.cfg.used & {8{st.afe_s2.burst}}));
            nx.gout = lvl[10:8];
        end

        // Restart as after power-up; synchronisers, chirp and PWM counters keep running, read data is kept
        if (st.soft_rst)
        begin
            nx.phase = PH_INIT;
            nx.tmr = 24'h00_0000;
            nx.cfg = CFG_RESET;
            nx.pend = 3'h0;
            nx.overrun = 1'b0;
            nx.awake = 1'b0;
            nx.lp_cnt = 8'h00;
            nx.awake_cnt = 8'h00;
            nx.key_prev = 16'h0000;
            nx.cal_all = 1'b0;
            nx.meas_req = 1'b0;
            nx.drv = 8'h00;
            nx.gout = 3'h0;
        end
        nx.alert = nx.pend != 3'h0;
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            st <= '0;
            st.cfg <= CFG_RESET;
        end
        else
            st <= nx;
    end

    // Outputs; APB answers in the first access cycle
    assign prdata = st.rdata;
    assign pready = psel & penable;
    assign pslverr = psel & penable & ~hit;
    assign meas_req = st.meas_req;
    assign key_cal = kcal;
    assign chirp_step = st.chirp;
    assign status_alert_n = ~st.alert;
    assign drive_line_outputs = st.drv;
    assign gpio_out = st.gout;
    // only dedicated pins may be inputs
    assign gpio_oe = st.cfg.dir;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    sequence init_end_s;
        $past(st.phase) == PH_INIT && st.phase == PH_IDLE;
    endsequence

    sequence cal_alert_s;
        !status_alert_n && kcal == 16'hFFFF;
    endsequence

    init_time_a: assert property (
        init_end_s |-> $past(st.tmr) == 24'(INIT_CYCLES - 1))
        else $error("startup period length wrong");

    init_cal_a: assert property (
        init_end_s |-> st.cal_all ##1 cal_alert_s)
        else $error("no alert and calibration after startup");

    recal_source_a: assert property (
        st.cal_all |-> $past(st.phase) == PH_INIT || $past(wr && paddr == A_CAL))
        else $error("full calibration without cause");

    key_alert_a: assert property (
        det != st.key_prev && !st.soft_rst |=> !status_alert_n)
        else $error("status change did not alert");

    overrun_flag_a: assert property (
        st.phase == PH_MEAS && tick && !st.soft_rst |=> st.overrun && st.phase != PH_INIT)
        else $error("cycle overrun not flagged");

    sleep_quiet_a: assert property (
        st.phase == PH_SLEEP && $past(st.phase) == PH_SLEEP && !$past(st.soft_rst)
        |-> !meas_req && $stable(drive_line_outputs) && $stable(gpio_out))
        else $error("activity while asleep");

    wake_src_a: assert property (
        st.phase == PH_SLEEP && (i2c_addr_match || (wr && paddr == A_LP && pwdata[7:0] != 8'h00))
        |=> st.phase != PH_SLEEP)
        else $error("missed wake source");

    alert_release_a: assert property (
        $rose(status_alert_n) |-> $past(rd) || $past(st.soft_rst))
        else $error("alert released without a read");
endmodule

// ---- sim/tb_top.sv ----
// Self-checking bench for the touch scan sequencer
`timescale 1ns/100ps
module tb_top;
    import tss_pkg::*;

    logic        sys_clk, resetn, psel, penable, pwrite, pready, pslverr, slv, hit;
    logic        meas_req, rst_pin_n, i2c_addr_match, status_alert_n;
    logic [7:0]  paddr, drive_line_outputs;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] key_cal, above_k;
    logic [3:0]  chirp_step, chirp0;
    logic [2:0]  gpio_in, gpio_out, gpio_oe;
    tss_afe_t    afe_in;
    int          error_cnt, num_checks;

    // Short counts keep the run brief
    tss_top #(.INIT_CYCLES(200), .CYCLE_CYCLES(200)) i_tss_top (.sys_clk(sys_clk), .resetn(resetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .afe_in(afe_in), .meas_req(meas_req), .key_cal(key_cal),
        .chirp_step(chirp_step), .rst_pin_n(rst_pin_n), .i2c_addr_match(i2c_addr_match),
        .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
        .drive_line_outputs(drive_line_outputs), .status_alert_n(status_alert_n));

    tss_afe_model i_tss_afe_model (.sys_clk(sys_clk), .meas_req(meas_req), .above_k(above_k), .afe(afe_in));

    // 200 MHz clock
    always #2.5 sys_clk = ~sys_clk;

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One APB transfer; read data and error taken at the pready edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        @(posedge sys_clk);
        while (pready !== 1'b1 && n < 20)
        begin
            n++;
            @(posedge sys_clk);
        end
        // A slave that never answers counts as a mismatch
        if (n == 20)
            error_cnt++;
        rd  = prdata;
        slv = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Off-edge settle so outputs are read after their update
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // Watch for a measurement request over a fixed span
    task automatic wait_req(input int lim);
        hit = 1'b0;
        repeat (lim)
        begin
            @(negedge sys_clk);
            if (meas_req === 1'b1) hit = 1'b1;
        end
    endtask

    // Status reads drop every pending alert source
    task automatic clear_alert;
        apb(1'b0, A_GEN, '0);
        apb(1'b0, A_KEYS, '0);
        apb(1'b0, A_GPIN, '0);
    endtask

    task automatic results;
        $display("error_cnt %0d num_checks %0d", error_cnt, num_checks);
        if (error_cnt == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Watchdog well beyond the expected run
    initial
    begin
        #400000;
        error_cnt++;
        results();
    end

    // Main sequence
    initial
    begin
        {psel, penable, pwrite, i2c_addr_match, resetn} = '0;
        {paddr, pwdata, gpio_in, above_k} = '0;
        sys_clk = 1'b0;
        rst_pin_n = 1'b1;
        error_cnt = 0;
        num_checks = 0;
        repeat (8) @(posedge sys_clk);
        resetn <= 1'b1;
        chk("alert_rst", 1'h1, status_alert_n);
        apb(1'b0, A_LP, '0);
        chk("lp_rst", 8'h01, rd);
        apb(1'b0, A_DI, '0);
        chk("di_rst", 8'h04, rd);
        apb(1'b1, 8'h3C, 32'h0000_0005);
        chk("unmapped", 1'h1, slv);
        cyc(200);
        chk("alert_init", 1'h0, status_alert_n);
        chk("cal_init", 16'hFFFF, key_cal);
        clear_alert();
        cyc(2);
        chk("alert_clr", 1'h1, status_alert_n);
        above_k = 16'h0001;
        cyc(5000);
        chk("alert_key", 1'h0, status_alert_n);
        apb(1'b0, A_KEYS, '0);
        chk("key_det", 16'h0001, rd);
        above_k = 16'h0000;
        cyc(600);
        clear_alert();
        apb(1'b0, A_KEYS, '0);
        chk("key_rel", 16'h0000, rd);
        apb(1'b1, A_CAL, 32'h0000_0001);
        cyc(10);
        chk("cal_cmd", 16'hFFFF, key_cal);
        chk("cal_quiet", 1'h1, status_alert_n);
        apb(1'b1, A_DIR, 32'h0000_0007);
        apb(1'b1, A_DRIVE, 32'h0000_05A5);
        cyc(3);
        chk("gpio_oe", 3'h7, gpio_oe);
        chk("gpio_out", 3'h5, gpio_out);
        chk("drive_out", 8'hA5, drive_line_outputs);
        apb(1'b1, A_DIR, 32'h0000_0000);
        apb(1'b1, A_WAKE, 32'h0000_0001);
        apb(1'b1, A_AWAKE, 32'h0000_0001);
        apb(1'b1, A_LP, 32'h0000_0000);
        cyc(3200);
        wait_req(600);
        chk("sleep_req", 1'h0, hit);
        chk("drv_sleep", 8'hA5, drive_line_outputs);
        clear_alert();
        @(posedge sys_clk) gpio_in <= 3'h1;
        cyc(8);
        chk("wake_pin", 1'h0, status_alert_n);
        chirp0 = chirp_step;
        @(posedge sys_clk) i2c_addr_match <= 1'b1;
        @(posedge sys_clk) i2c_addr_match <= 1'b0;
        wait_req(450);
        chk("wake_addr", 1'h1, hit);
        cyc(100);
        chk("chirp", 4'(chirp0 + 4'h1), chirp_step);
        apb(1'b1, A_DI, 32'h0000_0006);
        @(posedge sys_clk) rst_pin_n <= 1'b0;
        repeat (100) @(posedge sys_clk);
        rst_pin_n <= 1'b1;
        cyc(20);
        apb(1'b0, A_DI, '0);
        chk("rst_short", 8'h06, rd);
        @(posedge sys_clk) rst_pin_n <= 1'b0;
        repeat (2100) @(posedge sys_clk);
        rst_pin_n <= 1'b1;
        cyc(20);
        apb(1'b0, A_DI, '0);
        chk("rst_long", 8'h04, rd);
        results();
    end
endmodule

// ---- sim/tss_afe_model.sv ----
// Front end model: answers each measurement request with one link frame
`timescale 1ns/100ps
module tss_afe_model (
    input  wire logic         sys_clk,
    input  wire logic         meas_req,
    input  wire logic [15:0]  above_k,
    output tss_pkg::tss_afe_t afe
);
    import tss_pkg::*;

    // One frame per request; link clock stands low between frames
    initial
    begin
        afe = '0;
        forever
        begin
            @(negedge sys_clk iff meas_req === 1'b1);
            #51.3 afe.burst = 1'b1;
            afe.pulses = 8'h5A;
            #62.5 afe.lclk = 1'b1;
            #62.5 afe.lclk = 1'b0;
            afe.burst = 1'b0;
            afe.pulses = 8'hA5;
            afe.above = above_k;
            afe.pos_over = 16'h0000;
            afe.done = 1'b1;
            #62.5 afe.lclk = 1'b1;
            #62.5 afe.lclk = 1'b0;
            // Released result lines show junk, never the last value
            afe.done = 1'b0;
            afe.above = ~afe.above;
            afe.pos_over = ~afe.pos_over;
        end
    end
endmodule
